//--- core_ctrl_pkg.sv
// Package of constants for the core implementation control bits
package core_ctrl_pkg;

  // ==========================================================================
  // Register access
  // Special register number that reaches the control register
  localparam logic [9:0]  SPR_CORE_IMPL_CTRL = 10'h3F0;
  localparam logic [31:0] CTRL_RESET_VALUE   = 32'h0000_0000;

  // ==========================================================================
  // Field positions, numbered from the MSB as bit 0, mapped to vector index
  localparam int REG_MSB           = 31;
  localparam int BIT_ADDR_PAR      = REG_MSB - 2;
  localparam int BIT_DATA_PAR      = REG_MSB - 3;
  localparam int BIT_CLKOUT_A      = REG_MSB - 4;
  localparam int BIT_LEGACY_CMP    = REG_MSB - 5;
  localparam int BIT_CLKOUT_B      = REG_MSB - 6;
  localparam int BIT_LEGACY_RETRY  = REG_MSB - 7;
  localparam int BIT_DOZE_EN       = REG_MSB - 8;
  localparam int BIT_NAP_EN        = REG_MSB - 9;
  localparam int BIT_SLEEP_EN      = REG_MSB - 10;
  localparam int BIT_AUTO_GATE     = REG_MSB - 11;

  // Only implemented bits are writable; all others read zero
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h3AF0_0000;

  // ==========================================================================
  // Timing
  // Core clocks between peripheral grant and entry into nap or sleep
  localparam int ENTRY_CYCLES_DEFAULT = 4;

  // Clock output select value that hands the pin to the control bits
  localparam logic [1:0] CLKOUT_SEL_CTRL_BITS = 2'h0;

  // ==========================================================================
  // Power state machine
  typedef enum logic [2:0] {
    PM_RUN,
    PM_DOZE,
    PM_NAP_WAIT,
    PM_NAP_ENTER,
    PM_NAP,
    PM_SLEEP_WAIT,
    PM_SLEEP_ENTER,
    PM_SLEEP
  } pm_state_t;

endpackage

//--- core_impl_ctrl.sv
// Core implementation control bits: parity, clock output, power modes
`timescale 1ns/1ps
`default_nettype none

module core_impl_ctrl
  import core_ctrl_pkg::*;
#(
  parameter int UNIT_COUNT   = 4,
  parameter int ENTRY_CYCLES = ENTRY_CYCLES_DEFAULT
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // Special register move port
  input  wire logic                  spr_wr_i,
  input  wire logic                  spr_rd_i,
  input  wire logic [9:0]            spr_num_i,
  input  wire logic [31:0]           spr_wdata_i,
  output logic      [31:0]           spr_rdata_o,
  // Parity checking
  input  wire logic                  machine_check_enable_i,
  input  wire logic                  addr_parity_err_i,
  input  wire logic                  data_parity_err_i,
  output logic                       machine_check_o,
  output logic                       checkstop_o,
  // Clock output configuration
  input  wire logic [1:0]            clkout_source_select_i,
  input  wire logic                  hard_reset_done_i,
  output logic                       clock_output_pin_en_o,
  output logic      [1:0]            clock_output_type_o,
  // Power saving
  input  wire logic                  power_save_request_i,
  input  wire logic                  snoop_done_i,
  input  wire logic                  peri_power_save_i,
  output logic                       nap_ready_o,
  output logic                       sleep_ready_o,
  output logic                       core_doze_o,
  output logic                       core_nap_o,
  output logic                       core_sleep_o,
  output logic                       core_activity_en_o,
  output logic                       snoop_en_o,
  output logic                       pll_run_o,
  output logic                       timebase_run_o,
  output logic                       quiesce_acknowledge_o,
  // Dynamic unit power management
  input  wire logic [UNIT_COUNT-1:0] unit_idle_i,
  output logic      [UNIT_COUNT-1:0] unit_low_power_o
);

  // ==========================================================================
  // Parameter checks, refused at elaboration rather than at run time
  if (UNIT_COUNT < 1) $error("UNIT_COUNT must be at least 1");
  if (ENTRY_CYCLES < 1) $error("ENTRY_CYCLES must be at least 1");
  localparam int CNT_W = (ENTRY_CYCLES > 1) ? $clog2(ENTRY_CYCLES + 1) : 1;
  localparam logic [CNT_W-1:0] ENTRY_LAST = CNT_W'(ENTRY_CYCLES - 1);

  // ==========================================================================
  // Control register
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [31:0] spr_rdata_reg;
  logic        spr_hit;

  // Decode of the special register number, shared by read and write
  function automatic logic spr_match(input logic [9:0] num);
    spr_match = (num == SPR_CORE_IMPL_CTRL);
  endfunction

  assign spr_hit = spr_match(spr_num_i);

  // Reserved and out-of-block bits never store anything
  always_comb begin
    ctrl_next = ctrl_reg;
    if (spr_wr_i && spr_hit) begin
      ctrl_next = spr_wdata_i & CTRL_WRITE_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RESET_VALUE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Reads of other numbers return zero rather than stale data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spr_rdata_reg <= 32'h0000_0000;
    end else if (spr_rd_i) begin
      spr_rdata_reg <= spr_hit ? ctrl_reg : 32'h0000_0000;
    end
  end

  assign spr_rdata_o = spr_rdata_reg;

  // ==========================================================================
  // Parity checking
  logic addr_par_en;
  logic data_par_en;
  logic parity_fault;
  logic machine_check_reg;
  logic checkstop_reg;

  assign addr_par_en  = ctrl_reg[BIT_ADDR_PAR];
  assign data_par_en  = ctrl_reg[BIT_DATA_PAR];
  assign parity_fault = (addr_parity_err_i && addr_par_en)
                     || (data_parity_err_i && data_par_en);

  // Checkstop holds until reset since the core stops dead
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      machine_check_reg <= 1'b0;
      checkstop_reg     <= 1'b0;
    end else begin
      machine_check_reg <= parity_fault && machine_check_enable_i;
      if (parity_fault && !machine_check_enable_i) begin
        checkstop_reg <= 1'b1;
      end
    end
  end

  assign machine_check_o = machine_check_reg;
  assign checkstop_o     = checkstop_reg;

  // ==========================================================================
  // Clock output configuration
  logic       clkout_en_reg;
  logic [1:0] clkout_type_reg;
  logic [1:0] clkout_bits;

  assign clkout_bits = {ctrl_reg[BIT_CLKOUT_A], ctrl_reg[BIT_CLKOUT_B]};

  // Other select values leave the pin to the outside clock logic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clkout_en_reg   <= 1'b0;
      clkout_type_reg <= 2'h0;
    end else if (clkout_source_select_i == CLKOUT_SEL_CTRL_BITS) begin
      clkout_en_reg   <= hard_reset_done_i && (clkout_bits != 2'h0);
      clkout_type_reg <= clkout_bits;
    end else begin
      clkout_en_reg   <= 1'b0;
      clkout_type_reg <= 2'h0;
    end
  end

  assign clock_output_pin_en_o = clkout_en_reg;
  assign clock_output_type_o   = clkout_type_reg;

  // ==========================================================================
  // Power state machine
  pm_state_t        pm_reg;
  pm_state_t        pm_next;
  logic             pow_prev_reg;
  logic             pow_rise;
  logic [CNT_W-1:0] entry_cnt_reg;

  // Entry needs the request to rise after the mode bit is set
  assign pow_rise = power_save_request_i && !pow_prev_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pow_prev_reg <= 1'b0;
    end else begin
      pow_prev_reg <= power_save_request_i;
    end
  end

  // Deepest enabled mode wins when several are set
  always_comb begin
    pm_next = pm_reg;
    case (pm_reg)
      PM_RUN: begin
        if (pow_rise && ctrl_reg[BIT_SLEEP_EN]) begin
          pm_next = PM_SLEEP_WAIT;
        end else if (pow_rise && ctrl_reg[BIT_NAP_EN]) begin
          pm_next = PM_NAP_WAIT;
        end else if (pow_rise && ctrl_reg[BIT_DOZE_EN]) begin
          pm_next = PM_DOZE;
        end
      end
      PM_NAP_WAIT: begin
        if (snoop_done_i) begin
          pm_next = PM_NAP_ENTER;
        end
      end
      PM_NAP_ENTER: begin
        if (entry_cnt_reg == ENTRY_LAST) begin
          pm_next = PM_NAP;
        end
      end
      PM_SLEEP_WAIT: begin
        if (snoop_done_i) begin
          pm_next = PM_SLEEP_ENTER;
        end
      end
      PM_SLEEP_ENTER: begin
        if (entry_cnt_reg == ENTRY_LAST) begin
          pm_next = PM_SLEEP;
        end
      end
      PM_DOZE, PM_NAP, PM_SLEEP: begin
        pm_next = pm_reg;
      end
      default: begin
        pm_next = PM_RUN;
      end
    endcase
    // Dropping the request wakes the core from any state
    if (!power_save_request_i) begin
      pm_next = PM_RUN;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pm_reg <= PM_RUN;
    end else begin
      pm_reg <= pm_next;
    end
  end

  // Entry delay counts only inside the two entering states
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      entry_cnt_reg <= '0;
    end else if (pm_reg == PM_NAP_ENTER || pm_reg == PM_SLEEP_ENTER) begin
      entry_cnt_reg <= entry_cnt_reg + CNT_W'(1);
    end else begin
      entry_cnt_reg <= '0;
    end
  end

  // Ready stays up until the peripheral grants entry
  assign nap_ready_o   = (pm_reg == PM_NAP_WAIT);
  assign sleep_ready_o = (pm_reg == PM_SLEEP_WAIT);
  assign core_doze_o   = (pm_reg == PM_DOZE);
  assign core_nap_o    = (pm_reg == PM_NAP);
  assign core_sleep_o  = (pm_reg == PM_SLEEP);

  // Doze keeps snooping; nap stops all but PLL and time base, sleep stops all but PLL
  assign core_activity_en_o = (pm_reg != PM_DOZE) && !core_nap_o && !core_sleep_o;
  assign snoop_en_o         = !core_nap_o && !core_sleep_o;
  // PLL stop in sleep is left to the outside logic, which bypasses it first
  assign pll_run_o          = 1'b1;
  assign timebase_run_o     = !core_sleep_o;

  // ==========================================================================
  // Quiesce acknowledge tracks the peripheral, not the core state
  logic quiesce_acknowledge_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiesce_acknowledge_reg <= 1'b0;
    end else begin
      quiesce_acknowledge_reg <= peri_power_save_i;
    end
  end

  assign quiesce_acknowledge_o = quiesce_acknowledge_reg;

  // ==========================================================================
  // Dynamic power management; no stall, so software never sees it
  logic [UNIT_COUNT-1:0] unit_lp_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_lp_reg <= '0;
    end else begin
      unit_lp_reg <= unit_idle_i & {UNIT_COUNT{ctrl_reg[BIT_AUTO_GATE]}};
    end
  end

  assign unit_low_power_o = unit_lp_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reserved_read_zero_a: assert property (
    (spr_rdata_o & ~CTRL_WRITE_MASK) == 32'h0000_0000)
    else $error("Reserved bit read back nonzero");
  spr_write_store_a: assert property (
    spr_wr_i && spr_hit |=> ctrl_reg == ($past(spr_wdata_i) & CTRL_WRITE_MASK))
    else $error("Matching write not stored");
  spr_other_ignore_a: assert property (
    !(spr_wr_i && spr_hit) |=> $stable(ctrl_reg))
    else $error("Control register changed without matching write");
  parity_mc_raise_a: assert property (
    addr_parity_err_i && addr_par_en && machine_check_enable_i |=> machine_check_o)
    else $error("Address parity error missed machine check");
  parity_checkstop_a: assert property (
    data_parity_err_i && data_par_en && !machine_check_enable_i |=> checkstop_o)
    else $error("Data parity error missed checkstop");
  parity_off_quiet_a: assert property (
    !addr_par_en && !data_par_en && !checkstop_o |=> !machine_check_o && !checkstop_o)
    else $error("Parity fault raised while checking off");
  nap_needs_grant_a: assert property (
    nap_ready_o && !snoop_done_i && power_save_request_i |=> !core_nap_o)
    else $error("Nap entered without grant");
  sleep_entry_delay_a: assert property (
    sleep_ready_o && snoop_done_i && power_save_request_i [*1]
      ##1 power_save_request_i [*4] |=> core_sleep_o || ENTRY_CYCLES > 4)
    else $error("Sleep not entered after grant and delay");
  nap_clocks_run_a: assert property (
    core_nap_o |-> pll_run_o && timebase_run_o && !core_activity_en_o)
    else $error("Nap state clocks wrong");
  doze_snoop_on_a: assert property (
    ctrl_reg[BIT_DOZE_EN] && !ctrl_reg[BIT_NAP_EN] && !ctrl_reg[BIT_SLEEP_EN]
      && pow_rise |=> core_doze_o && snoop_en_o && timebase_run_o)
    else $error("Doze not entered with snooping on");
  quiesce_acknowledge_follow_a: assert property (
    ##1 quiesce_acknowledge_o == $past(peri_power_save_i))
    else $error("Quiesce acknowledge not following peripheral");
  unit_gate_a: assert property (
    ##1 unit_low_power_o == ($past(unit_idle_i) & {UNIT_COUNT{$past(ctrl_reg[BIT_AUTO_GATE])}}))
    else $error("Unit low power does not match idle and enable");
  clkout_cfg_a: assert property (
    clkout_source_select_i != CLKOUT_SEL_CTRL_BITS |=> !clock_output_pin_en_o)
    else $error("Clock output driven while not selected");
endmodule

`default_nettype wire

//--- peri_logic_model.sv
// Peripheral logic model facing the core power-saving handshake
`timescale 1ns/1ps
`default_nettype none

module peri_logic_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic slow_i,
  input  wire logic nap_ready_i,
  input  wire logic sleep_ready_i,
  input  wire logic power_save_request_i,
  input  wire logic core_sleep_i,
  output logic      snoop_done_o,
  output logic      peri_power_save_o,
  output logic      pll_bypass_o,
  output logic      sys_clk_gate_o
);
  logic [3:0] wait_reg;
  logic [4:0] pace_reg;

  // ==========================================================================
  // Grant
  // Grant only once snoop traffic has drained; held until the request drops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg     <= 4'h0;
      snoop_done_o <= 1'b0;
    end else if (!power_save_request_i) begin
      wait_reg     <= 4'h0;
      snoop_done_o <= 1'b0;
    end else if ((nap_ready_i || sleep_ready_i) && !snoop_done_o) begin
      wait_reg <= wait_reg + 4'h1;
      if (wait_reg >= (slow_i ? 4'h6 : 4'h0)) begin
        snoop_done_o <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Own power state, paced apart from the core on purpose
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pace_reg <= 5'h00;
    end else begin
      pace_reg <= pace_reg + 5'h01;
    end
  end
  assign peri_power_save_o = pace_reg[3];

  // ==========================================================================
  // PLL stop in sleep: bypass first, gate one edge later
  // The gate is only a flag here; the model clock keeps running for the bench
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_bypass_o   <= 1'b0;
      sys_clk_gate_o <= 1'b0;
    end else begin
      pll_bypass_o   <= core_sleep_i;
      sys_clk_gate_o <= core_sleep_i && pll_bypass_o;
    end
  end

endmodule
`default_nettype wire

//--- tb_core_impl_ctrl.sv
// Self-checking testbench for the core implementation control bits
`timescale 1ns/1ps
`default_nettype none

module tb_core_impl_ctrl;
  import core_ctrl_pkg::*;
  localparam int          EC = 2;
  localparam logic [9:0]  SN = SPR_CORE_IMPL_CTRL;
  logic clk_i = 0, rst_n_i = 0, spr_wr_i = 0, spr_rd_i = 0, me = 0, ape = 0, dpe = 0;
  logic [9:0]  spr_num_i = 10'h000;
  logic [31:0] spr_wdata_i = 32'h0, rdata;
  logic [1:0]  sel = 2'h0, ctype;
  logic [3:0]  idle = 4'h0, ulp;
  logic        hrd = 0, pow = 0, slow = 0, mc, cs, cken, sdone, pps, pps_d, rd_pend = 0;
  logic        nrdy, srdy, dz, np, sl, act, snp, pll, tbr, quiesce_acknowledge, byp, cgate;
  logic [31:0] exp_q[$];
  integer      seed = 32'h544934cb, miscompares = 0, n_compared = 0, cycles = 0, i, k;

  core_impl_ctrl #(.UNIT_COUNT(4), .ENTRY_CYCLES(EC)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .spr_wr_i(spr_wr_i), .spr_rd_i(spr_rd_i),
    .spr_num_i(spr_num_i), .spr_wdata_i(spr_wdata_i), .spr_rdata_o(rdata),
    .machine_check_enable_i(me), .addr_parity_err_i(ape), .data_parity_err_i(dpe),
    .machine_check_o(mc), .checkstop_o(cs), .clkout_source_select_i(sel),
    .hard_reset_done_i(hrd), .clock_output_pin_en_o(cken), .clock_output_type_o(ctype),
    .power_save_request_i(pow), .snoop_done_i(sdone), .peri_power_save_i(pps),
    .nap_ready_o(nrdy), .sleep_ready_o(srdy), .core_doze_o(dz), .core_nap_o(np),
    .core_sleep_o(sl), .core_activity_en_o(act), .snoop_en_o(snp), .pll_run_o(pll),
    .timebase_run_o(tbr), .quiesce_acknowledge_o(quiesce_acknowledge), .unit_idle_i(idle),
    .unit_low_power_o(ulp));

  peri_logic_model peri_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .nap_ready_i(nrdy),
    .sleep_ready_i(srdy), .power_save_request_i(pow), .snoop_done_o(sdone),
    .peri_power_save_o(pps), .core_sleep_i(sl), .pll_bypass_o(byp),
    .sys_clk_gate_o(cgate));

  // ==========================================================================
  // Clock and hang guard
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
    n_compared = n_compared + 1;
    if (got !== want) begin
      $display("wrong value at %0t: %s", $time, m);
      miscompares = miscompares + 1;
    end
  endtask

  // ==========================================================================
  // Bus tasks; reads note the expected word for the watcher
  task automatic wr(input logic [9:0] n, input logic [31:0] d);
    @(negedge clk_i);
    spr_wr_i = 1;
    spr_num_i = n;
    spr_wdata_i = d;
    @(negedge clk_i);
    spr_wr_i = 0;
  endtask

  task automatic rd(input logic [9:0] n, input logic [31:0] e);
    @(negedge clk_i);
    exp_q.push_back(e);
    spr_rd_i = 1;
    spr_num_i = n;
    @(negedge clk_i);
    spr_rd_i = 0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic do_reset();
    rst_n_i = 0;
    cyc(20);
    rst_n_i = 1;
  endtask

  // ==========================================================================
  // Watcher: read data one edge after the strobe; quiesce one edge late
  always @(posedge clk_i) begin
    rd_pend <= spr_rd_i;
    pps_d <= pps;
  end
  always @(negedge clk_i) begin
    if (rd_pend && exp_q.size() > 0) chk(rdata, exp_q.pop_front(), "read data");
    if (rst_n_i) chk(quiesce_acknowledge, pps_d, "quiesce");
    if (cgate) chk(byp, 1, "clock gated before bypass");
  end

  // Power mode entry and exit through the partner handshake
  task automatic power(input int b, input logic s);
    int n;
    logic [3:0] want;
    slow = s;
    wr(SN, 32'h1 << b);
    pow = 1;
    n = 0;
    while (np !== 1'b1 && sl !== 1'b1 && dz !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      if (sdone !== 1'b1) chk(np | sl, 0, "entry before grant");
      n = (sdone === 1'b1) ? n + 1 : n;
      if (b == BIT_DOZE_EN) n = 40;
    end
    // n spans the first negedge showing the grant through the one showing the mode
    if (b != BIT_DOZE_EN) chk(n, EC + 2, "entry delay");
    // Two edges in the mode keep the request up long enough for the entry check
    cyc(2);
    chk({dz, np, sl}, {b == BIT_DOZE_EN, b == BIT_NAP_EN, b == BIT_SLEEP_EN}, "mode");
    want = {1'b1, b != BIT_SLEEP_EN, b == BIT_DOZE_EN, 1'b0};
    chk({pll, tbr, snp, act}, want, "clocks");
    chk({byp, cgate}, {b == BIT_SLEEP_EN, b == BIT_SLEEP_EN}, "pll stop");
    pow = 0;
    cyc(2);
    chk({dz, np, sl, act}, 4'h1, "wake");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    do_reset();
    rd(SN, CTRL_RESET_VALUE);
    wr(SN, 32'hFFFF_FFFF);
    rd(SN, CTRL_WRITE_MASK);
    wr(SN + 10'h001, 32'h0);
    rd(SN, CTRL_WRITE_MASK);
    rd(SN + 10'h001, 32'h0);
    for (i = 0; i < 8; i++) begin
      spr_wdata_i = $random(seed);
      k = spr_wdata_i;
      wr(SN, k);
      rd(SN, k & CTRL_WRITE_MASK);
    end
    // Both parity kinds, enabled then disabled, machine check taken
    me = 1;
    for (i = 0; i < 4; i++) begin
      wr(SN, (i < 2) ? ((32'h1 << BIT_ADDR_PAR) | (32'h1 << BIT_DATA_PAR)) : 32'h0);
      {ape, dpe} = i[0] ? 2'b01 : 2'b10;
      cyc(1);
      {ape, dpe} = 2'b00;
      chk({mc, cs}, {i < 2, 1'b0}, "parity fault");
      cyc(1);
      chk(mc, 0, "machine check pulse");
    end
    // Clock output pin: every bit pair, then another source and no reset done
    for (i = 0; i < 12; i++) begin
      k = i % 4;
      hrd = (i < 8);
      sel = (i >= 4 && i < 8) ? 2'h1 : 2'h0;
      wr(SN, ((k / 2) << BIT_CLKOUT_A) | ((k % 2) << BIT_CLKOUT_B));
      cyc(2);
      // Another source parks the type at zero as well as the enable
      chk({cken, ctype}, {hrd && !sel && k != 0, sel ? 2'h0 : k[1:0]}, "clock output");
    end
    power(BIT_DOZE_EN, 0);
    power(BIT_NAP_EN, 0);
    power(BIT_SLEEP_EN, 1);
    // Idle unit gating with the enable on, then off
    for (i = 0; i < 16; i++) begin
      if (i % 8 == 0) wr(SN, (i < 8) ? (32'h1 << BIT_AUTO_GATE) : 32'h0);
      cyc(1);
      idle = 4'($random(seed));
      cyc(1);
      chk(ulp, (i < 8) ? idle : 4'h0, "unit gating");
    end
    // Checkstop with machine check disabled stays until reset
    me = 0;
    wr(SN, 32'h1 << BIT_DATA_PAR);
    dpe = 1;
    cyc(1);
    dpe = 0;
    cyc(3);
    chk({cs, mc}, 2'b10, "checkstop");
    do_reset();
    chk(cs, 0, "checkstop cleared");
    conclude();
  end

endmodule
`default_nettype wire
